//--- core/ufe_pkg.sv
// constants and register map of the usb host event and frame timer block
// ****************************************************************************
// Overview of operation
// - enable bit 9 passes the frame-timer expiry interrupt; zero blocks it
// - enable bits 7 and 6 gate remote-wakeup interrupts of port b and port a
// - enable bits 5 and 4 gate connect changes, se0 to j or j to se0
// - enable bit 0 gates transfer done for both ports
// - writing one to a status flag clears it; writing zero leaves it alone
// - host status register is reachable through the host parallel port
// - status bit 15 sets on both vbus valid edges, first host only
// - status bit 14 sets on both otg id edges, first host only
// - status bit 9 sets when the frame down counter expires
// - status bits 7 and 6 set on remote wakeup of port b and port a
// - status bits 5 and 4 set on start or end of se0 on port b, port a
// - status bits 3 and 2 show live se0 of port b and port a
// - status bit 0 sets when a transfer completes, shared by both ports
// - frame counter reloads from the 14-bit reload field on reaching zero
// - reload field defaults to 0x2ee0 after reset, a 1 ms frame
// - frame counter counts down once per 12 mhz timebase cycle
// - reading the reload register returns the programmed reload value
// - each write to the reload register clears that host's frame number
// - current counter value is readable in a separate read-only register
// ****************************************************************************
package ufe_pkg;

   // ************************************************************************
   // port widths
   // ************************************************************************
   localparam int ADDR_W   = 16;
   localparam int DATA_W   = 16;
   localparam int RELOAD_W = 14;
   localparam int N_HOST   = 2;

   // ************************************************************************
   // register addresses, index 0 is the first host, index 1 the second
   // ************************************************************************
   localparam logic [1:0][15:0] IEN_ADDR    = {16'hc0ac, 16'hc08c};
   localparam logic [1:0][15:0] STAT_ADDR   = {16'hc0b0, 16'hc090};
   localparam logic [1:0][15:0] RELOAD_ADDR = {16'hc0b2, 16'hc092};
   localparam logic [1:0][15:0] COUNT_ADDR  = {16'hc0b4, 16'hc094};

   // ************************************************************************
   // field positions inside the enable and status registers
   // ************************************************************************
   localparam int BIT_VBUS   = 15;
   localparam int BIT_ID     = 14;
   localparam int BIT_FRAME  = 9;
   localparam int BIT_WAKE_B = 7;
   localparam int BIT_WAKE_A = 6;
   localparam int BIT_CONN_B = 5;
   localparam int BIT_CONN_A = 4;
   localparam int BIT_SE0_B  = 3;
   localparam int BIT_SE0_A  = 2;
   localparam int BIT_DONE   = 0;

   // implemented enable and flag bits; otg bits exist in the first host only
   localparam logic [1:0][15:0] EVT_MASK = {16'h02f1, 16'hc2f1};

   // ************************************************************************
   // values after reset
   // ************************************************************************
   localparam logic [15:0]         IEN_RST    = 16'h0000;
   localparam logic [15:0]         FLAG_RST   = 16'h0000;
   localparam logic [RELOAD_W-1:0] RELOAD_RST = 14'h2ee0;

   // ************************************************************************
   // 12 mhz timebase made from the 20 mhz system clock by a fractional step
   // ************************************************************************
   localparam int          CLK_HZ  = 20_000_000;
   localparam int          TB_HZ   = 12_000_000;
   localparam logic [4:0]  TB_STEP = 5'(TB_HZ / 1_000_000);
   localparam logic [5:0]  TB_MOD  = 6'(CLK_HZ / 1_000_000);

endpackage : ufe_pkg

//--- core/ufe_frame_timer.sv
// frame down counter with automatic reload and expiry pulse
`timescale 1ns/100ps
module ufe_frame_timer
   import ufe_pkg::*;
#(
   parameter int CNT_W = RELOAD_W
)
(
   input  wire logic             sys_clk_i,
   input  wire logic             srst_i,
   input  wire logic             tick_i,
   input  wire logic [CNT_W-1:0] reload_i,
   output logic      [CNT_W-1:0] cnt_o,
   output logic                  expire_o
);

   // ************************************************************************
   // state
   // ************************************************************************
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             expire;
   } ufe_tmr_t;

   ufe_tmr_t st_r;
   ufe_tmr_t st_nxt;

   // count down on each timebase tick, reload and flag on zero
   always_comb
   begin
      st_nxt        = st_r;
      st_nxt.expire = 1'b0;
      if (tick_i)
      begin
         if (st_r.cnt == '0)
         begin
            st_nxt.cnt    = reload_i;
            st_nxt.expire = 1'b1;
         end
         else
         begin
            st_nxt.cnt = st_r.cnt - 1'b1;
         end
      end
   end

   // register the state
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         st_r.cnt    <= CNT_W'(RELOAD_RST);
         st_r.expire <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign cnt_o    = st_r.cnt;
   assign expire_o = st_r.expire;

   // ************************************************************************
   // checks
   // ************************************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);

   a_zero_reload: assert property (
      tick_i && cnt_o == '0 |=> expire_o && cnt_o == $past(reload_i))
      else $error("counter did not reload at zero");

   a_count_down: assert property (
      tick_i && cnt_o != '0 |=> !expire_o && cnt_o == $past(cnt_o) - 1'b1)
      else $error("counter did not step down on tick");

   a_hold_idle: assert property (
      !tick_i |=> $stable(cnt_o) && !expire_o)
      else $error("counter moved without a tick");

endmodule : ufe_frame_timer

//--- core/ufe_host_events.sv
// host event flags, interrupt enables and frame timers of two host engines
`timescale 1ns/100ps
module ufe_host_events
   import ufe_pkg::*;
(
   input  wire logic              sys_clk_i,
   input  wire logic              srst_i,
   // host parallel port register access
   input  wire logic [ADDR_W-1:0] hpp_addr_i,
   input  wire logic              hpp_wr_i,
   input  wire logic              hpp_rd_i,
   input  wire logic [DATA_W-1:0] hpp_wdata_i,
   output logic      [DATA_W-1:0] hpp_rdata_o,
   // line and otg pins, asynchronous
   input  wire logic [3:0]        se0_i,
   input  wire logic              vbus_valid_i,
   input  wire logic              otg_id_i,
   // event pulses from the serial engines, same clock
   input  wire logic [3:0]        wake_det_i,
   input  wire logic [1:0]        xfer_done_i,
   // outputs
   output logic      [1:0]        irq_o,
   output logic      [1:0]        frame_num_clr_o
);

   // ************************************************************************
   // state of the block
   // ************************************************************************
   typedef struct packed {
      logic [1:0][15:0]         ien;      // interrupt enables per host
      logic [1:0][15:0]         flag;     // sticky event flags per host
      logic [1:0][RELOAD_W-1:0] reload;   // frame period reload per host
      logic [5:0]               pin_s1;   // first synchroniser stage
      logic [5:0]               pin_s2;   // second synchroniser stage
      logic [5:0]               pin_d;    // delayed copy for edge detect
      logic [4:0]               tb_acc;   // fractional timebase accumulator
      logic                     tick;     // one 12 mhz timebase step
      logic [15:0]              rdata;    // read data held for the port
      logic [1:0]               fclr;     // frame number clear pulses
   } ufe_state_t;

   ufe_state_t st_r;
   ufe_state_t st_nxt;

   // pin vector layout: se0 of h1a, h1b, h2a, h2b, then vbus, then id
   localparam int PIN_VBUS = 4;
   localparam int PIN_ID   = 5;

   logic [5:0]               pin_edge;
   logic [5:0]               acc_sum;
   logic [5:0]               acc_wrap;
   logic [1:0][RELOAD_W-1:0] tmr_cnt;
   logic [1:0]               tmr_exp;

   // ************************************************************************
   // frame timers, one per host
   // ************************************************************************
   for (genvar h = 0; h < N_HOST; h++)
   begin : g_tmr
      ufe_frame_timer #(
         .CNT_W    (RELOAD_W)
      ) u_tmr (
         .sys_clk_i (sys_clk_i),
         .srst_i    (srst_i),
         .tick_i    (st_r.tick),
         .reload_i  (st_r.reload[h]),
         .cnt_o     (tmr_cnt[h]),
         .expire_o  (tmr_exp[h])
      );
   end

   // ************************************************************************
   // edges of the synchronised pins and timebase step
   // ************************************************************************
   // both edges of each line; the first stage is read by nobody else
   assign pin_edge = st_r.pin_s2 ^ st_r.pin_d;
   assign acc_sum  = {1'b0, st_r.tb_acc} + {1'b0, TB_STEP};
   assign acc_wrap = acc_sum - TB_MOD;

   // next state: sync, timebase, flags, register writes and reads
   always_comb
   begin
      logic [15:0] set_v;
      logic [15:0] clr_v;
      set_v = '0;
      clr_v = '0;
      st_nxt = st_r;

      // two flip-flops before any logic looks at a pin
      st_nxt.pin_s1 = {otg_id_i, vbus_valid_i, se0_i};
      st_nxt.pin_s2 = st_r.pin_s1;
      st_nxt.pin_d  = st_r.pin_s2;

      // 12 of every 20 system clocks carry a timebase step
      if (acc_sum >= TB_MOD)
      begin
         st_nxt.tb_acc = acc_wrap[4:0];
         st_nxt.tick   = 1'b1;
      end
      else
      begin
         st_nxt.tb_acc = acc_sum[4:0];
         st_nxt.tick   = 1'b0;
      end

      // clear pulses last a single cycle
      st_nxt.fclr = 2'b00;
      if (hpp_rd_i)
      begin
         st_nxt.rdata = '0;   // unmapped addresses read as zero
      end

      for (int h = 0; h < N_HOST; h++)
      begin
         // events of this host
         set_v             = '0;
         set_v[BIT_FRAME]  = tmr_exp[h];
         set_v[BIT_WAKE_B] = wake_det_i[2*h+1];
         set_v[BIT_WAKE_A] = wake_det_i[2*h];
         set_v[BIT_CONN_B] = pin_edge[2*h+1];
         set_v[BIT_CONN_A] = pin_edge[2*h];
         set_v[BIT_DONE]   = xfer_done_i[h];
         // the second host has no otg pins; its bits stay reserved
         if (h == 0)
         begin
            set_v[BIT_VBUS] = pin_edge[PIN_VBUS];
            set_v[BIT_ID]   = pin_edge[PIN_ID];
         end

         // write one to clear; a new event in the same cycle wins
         clr_v = '0;
         if (hpp_wr_i && hpp_addr_i == STAT_ADDR[h])
         begin
            clr_v = hpp_wdata_i;
         end
         st_nxt.flag[h] = ((st_r.flag[h] & ~clr_v) | set_v) & EVT_MASK[h];

         // writes of enables and reload value
         if (hpp_wr_i)
         begin
            if (hpp_addr_i == IEN_ADDR[h])
            begin
               st_nxt.ien[h] = hpp_wdata_i & EVT_MASK[h];
            end
            else if (hpp_addr_i == RELOAD_ADDR[h])
            begin
               st_nxt.reload[h] = hpp_wdata_i[RELOAD_W-1:0];
               st_nxt.fclr[h]   = 1'b1;
            end
         end

         // reads through the host parallel port
         if (hpp_rd_i)
         begin
            if (hpp_addr_i == IEN_ADDR[h])
            begin
               st_nxt.rdata = st_r.ien[h];
            end
            else if (hpp_addr_i == STAT_ADDR[h])
            begin
               st_nxt.rdata             = st_r.flag[h];
               st_nxt.rdata[BIT_SE0_B]  = st_r.pin_s2[2*h+1];
               st_nxt.rdata[BIT_SE0_A]  = st_r.pin_s2[2*h];
            end
            else if (hpp_addr_i == RELOAD_ADDR[h])
            begin
               st_nxt.rdata = {2'b00, st_r.reload[h]};
            end
            else if (hpp_addr_i == COUNT_ADDR[h])
            begin
               st_nxt.rdata = {2'b00, tmr_cnt[h]};
            end
         end
      end
   end

   // register the state
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         st_r        <= '0;
         st_r.ien    <= {IEN_RST, IEN_RST};
         st_r.flag   <= {FLAG_RST, FLAG_RST};
         // the timers restart from the same default period
         st_r.reload <= {RELOAD_RST, RELOAD_RST};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ************************************************************************
   // outputs
   // ************************************************************************
   // request while any enabled flag is pending
   assign irq_o[0] = |(st_r.flag[0] & st_r.ien[0]);
   assign irq_o[1] = |(st_r.flag[1] & st_r.ien[1]);

   assign hpp_rdata_o     = st_r.rdata;
   assign frame_num_clr_o = st_r.fclr;

   // ************************************************************************
   // checks
   // ************************************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);

   // a pin change that holds for the sync delay
   sequence s_se0a_move;
      $changed(se0_i[0]) ##1 $stable(se0_i[0])[*2];
   endsequence

   sequence s_id_move;
      $changed(otg_id_i) ##1 $stable(otg_id_i)[*2];
   endsequence

   sequence s_vbus_move;
      $changed(vbus_valid_i) ##1 $stable(vbus_valid_i)[*2];
   endsequence

   // write that clears every flag of host 0 with no new event
   sequence s_clear_all_h0;
      hpp_wr_i && hpp_addr_i == STAT_ADDR[0] && hpp_wdata_i == 16'hffff
         && !tmr_exp[0] && pin_edge == 6'h00 && wake_det_i == 4'h0
         && xfer_done_i == 2'b00;
   endsequence

   // enables gate the request
   a_frame_gate: assert property (
      st_r.flag[0][BIT_FRAME] && st_r.ien[0][BIT_FRAME] |-> irq_o[0])
      else $error("enabled frame flag gave no request");

   a_wake_gate: assert property (
      st_r.flag[1] == 16'h0080 && !st_r.ien[1][BIT_WAKE_B] |-> !irq_o[1])
      else $error("disabled wake flag raised a request");

   // events set their sticky flags
   a_conn_edge: assert property (
      s_se0a_move |=> st_r.flag[0][BIT_CONN_A])
      else $error("se0 change did not set connect flag");

   a_done_flag: assert property (
      xfer_done_i[1] |=> st_r.flag[1][BIT_DONE] ##0 !$past(irq_o[1])
         || st_r.flag[1][BIT_DONE])
      else $error("transfer done did not set its flag");

   // write one clears, write zero keeps, a new event wins
   a_w1c_clear: assert property (
      hpp_wr_i && hpp_addr_i == STAT_ADDR[0] && hpp_wdata_i[BIT_WAKE_A]
         && !wake_det_i[0] |=> !st_r.flag[0][BIT_WAKE_A])
      else $error("write one did not clear the flag");

   a_w0_keep: assert property (
      hpp_wr_i && hpp_addr_i == STAT_ADDR[0] && !hpp_wdata_i[BIT_DONE]
         && st_r.flag[0][BIT_DONE] |=> st_r.flag[0][BIT_DONE])
      else $error("write zero cleared the flag");

   a_set_wins: assert property (
      hpp_wr_i && hpp_addr_i == STAT_ADDR[0] && hpp_wdata_i[BIT_DONE]
         && xfer_done_i[0] |=> st_r.flag[0][BIT_DONE])
      else $error("event lost against a clear");

   // register reads through the host parallel port
   a_stat_read: assert property (
      hpp_rd_i && hpp_addr_i == STAT_ADDR[0]
      |=> hpp_rdata_o[BIT_SE0_A] == $past(st_r.pin_s2[0])
         && hpp_rdata_o[BIT_WAKE_B] == $past(st_r.flag[0][BIT_WAKE_B]))
      else $error("status read returned wrong bits");

   a_se0_live: assert property (
      hpp_rd_i && hpp_addr_i == STAT_ADDR[1]
      |=> hpp_rdata_o[BIT_SE0_B] == $past(st_r.pin_s2[3]))
      else $error("port b se0 read wrong");

   // otg pins exist on the first host only
   a_vbus_edge: assert property (
      s_vbus_move |=> st_r.flag[0][BIT_VBUS])
      else $error("vbus change did not set its flag");

   a_id_edge: assert property (
      s_id_move |=> st_r.flag[0][BIT_ID])
      else $error("id change did not set its flag");

   a_otg_reserved: assert property (
      !st_r.flag[1][BIT_VBUS] && !st_r.flag[1][BIT_ID]
         && !st_r.ien[1][BIT_VBUS] && !st_r.ien[1][BIT_ID])
      else $error("otg bit set in the second host");

   a_frame_flag: assert property (
      tmr_exp[0] |=> st_r.flag[0][BIT_FRAME])
      else $error("expiry did not set the frame flag");

   a_wake_flag: assert property (
      wake_det_i[3] |=> st_r.flag[1][BIT_WAKE_B])
      else $error("wakeup did not set its flag");

   // timebase and values after reset
   a_tick_gap: assert property (
      st_r.tick |-> ##[1:2] st_r.tick)
      else $error("timebase step missing");

   a_reset_value: assert property (
      $fell(srst_i) |-> st_r.reload[0] == RELOAD_RST
         && st_r.reload[1] == RELOAD_RST)
      else $error("reload not at its reset value");

   a_reload_read: assert property (
      hpp_rd_i && hpp_addr_i == RELOAD_ADDR[1]
      |=> hpp_rdata_o == {2'b00, $past(st_r.reload[1])})
      else $error("reload read returned wrong value");

   a_fnum_clear: assert property (
      hpp_wr_i && hpp_addr_i == RELOAD_ADDR[0]
      |=> frame_num_clr_o[0] ##1 !frame_num_clr_o[0] || $past(hpp_wr_i))
      else $error("reload write did not clear frame number");

   a_fclr_quiet: assert property (
      !(hpp_wr_i && hpp_addr_i == RELOAD_ADDR[1]) |=> !frame_num_clr_o[1])
      else $error("frame number cleared without a write");

   a_count_read: assert property (
      hpp_rd_i && hpp_addr_i == COUNT_ADDR[0]
      |=> hpp_rdata_o == {2'b00, $past(tmr_cnt[0])})
      else $error("counter read returned wrong value");

   // request level follows the enabled flags
   a_irq_drop: assert property (
      s_clear_all_h0 |=> !irq_o[0])
      else $error("request stayed after all flags cleared");

   a_irq_rise: assert property (
      st_r.ien[0][BIT_DONE] && xfer_done_i[0]
         && !(hpp_wr_i && hpp_addr_i == IEN_ADDR[0]) |=> irq_o[0])
      else $error("enabled event gave no request");

   a_rdata_hold: assert property (
      !hpp_rd_i |=> $stable(hpp_rdata_o))
      else $error("read data moved without a read");

   a_ien_mask: assert property (
      hpp_wr_i && hpp_addr_i == IEN_ADDR[1]
      |=> st_r.ien[1] == ($past(hpp_wdata_i) & EVT_MASK[1]))
      else $error("enable write kept a reserved bit");

endmodule : ufe_host_events

//--- verif/ufe_usb_dev_model.sv
// behavioural usb devices and otg pins facing the host event block
`timescale 1ns/100ps
module ufe_usb_dev_model
(
   input  wire logic       sys_clk_i,
   input  wire logic [3:0] attach_i,
   input  wire logic [3:0] wake_req_i,
   input  wire logic [1:0] done_req_i,
   input  wire logic       vbus_i,
   input  wire logic       id_i,
   output logic      [3:0] se0_o,
   output logic      [3:0] wake_det_o,
   output logic      [1:0] xfer_done_o,
   output logic            vbus_valid_o,
   output logic            otg_id_o
);
   // pins start idle: all devices attached, no events
   initial
   begin
      se0_o        = 4'h0;
      wake_det_o   = 4'h0;
      xfer_done_o  = 2'h0;
      vbus_valid_o = 1'b0;
      otg_id_o     = 1'b0;
   end

   // line and otg levels move off the clock grid, as a cable would
   always @(attach_i or vbus_i or id_i)
   begin
      se0_o        <= #13 ~attach_i;
      vbus_valid_o <= #13 vbus_i;
      otg_id_o     <= #13 id_i;
   end

   // serial engine events are one-cycle pulses on the system clock
   always @(posedge sys_clk_i)
   begin
      wake_det_o  <= wake_req_i;
      xfer_done_o <= done_req_i;
   end
endmodule : ufe_usb_dev_model

//--- verif/test_ufe_host_events.sv
// self-checking bench of the usb host event and frame timer block
`timescale 1ns/100ps
module test_ufe_host_events
   import ufe_pkg::*;
;
   logic        sys_clk_i = 1'b0;
   logic        srst_i    = 1'b1;
   logic [15:0] hpp_addr_i = 16'h0, hpp_wdata_i = 16'h0, d, t1;
   logic        hpp_wr_i = 1'b0, hpp_rd_i = 1'b0;
   logic [3:0]  attach = 4'hf, wake_req = 4'h0;
   logic [1:0]  done_req = 2'h0;
   logic        vbus = 1'b0, id = 1'b0;
   wire  [15:0] hpp_rdata_o;
   wire  [3:0]  se0_i, wake_det_i;
   wire  [1:0]  xfer_done_i, irq_o, frame_num_clr_o;
   wire         vbus_valid_i, otg_id_i;
   int          n_errors = 0, n_compared = 0, cyc = 0, t0, h, p, b;
   int          clr_cnt [2] = '{0, 0};
   integer      seed = 32'h3bd5;

   ufe_host_events uut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
      .hpp_addr_i(hpp_addr_i), .hpp_wr_i(hpp_wr_i), .hpp_rd_i(hpp_rd_i),
      .hpp_wdata_i(hpp_wdata_i), .hpp_rdata_o(hpp_rdata_o),
      .se0_i(se0_i), .vbus_valid_i(vbus_valid_i), .otg_id_i(otg_id_i),
      .wake_det_i(wake_det_i), .xfer_done_i(xfer_done_i),
      .irq_o(irq_o), .frame_num_clr_o(frame_num_clr_o));

   ufe_usb_dev_model dev (.sys_clk_i(sys_clk_i), .attach_i(attach),
      .wake_req_i(wake_req), .done_req_i(done_req), .vbus_i(vbus),
      .id_i(id), .se0_o(se0_i), .wake_det_o(wake_det_i),
      .xfer_done_o(xfer_done_i), .vbus_valid_o(vbus_valid_i),
      .otg_id_o(otg_id_i));

   // ************************************************************************
   // clock, cycle count, clear-pulse monitor and hang guard
   // ************************************************************************
   always #25 sys_clk_i = ~sys_clk_i;
   always @(negedge sys_clk_i)
   begin
      cyc++;
      for (int i = 0; i < 2; i++)
         if (frame_num_clr_o[i] === 1'b1) clr_cnt[i]++;
      if (cyc == 60000)
      begin
         n_errors++;
         $display("Error at %0t: run did not finish in time", $time);
         print_verdict();
      end
   end

   // ************************************************************************
   // shared tasks
   // ************************************************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string what);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic reg_wr(input logic [15:0] a, input logic [15:0] v);
      @(negedge sys_clk_i);
      hpp_wr_i    = 1'b1;
      hpp_addr_i  = a;
      hpp_wdata_i = v;
      @(negedge sys_clk_i);
      hpp_wr_i = 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [15:0] a, output logic [15:0] v);
      @(negedge sys_clk_i);
      hpp_rd_i   = 1'b1;
      hpp_addr_i = a;
      @(negedge sys_clk_i);
      hpp_rd_i = 1'b0;
      @(negedge sys_clk_i);
      v = hpp_rdata_o;
   endtask : reg_rd

   // reads a register and compares it with the worked-out value
   task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
      logic [15:0] v;
      reg_rd(a, v);
      chk(v, exp, "register read");
   endtask : rd_chk

   // waits for the interrupt of one host under a bound
   task automatic wait_irq(input int hh);
      int n;
      n = 0;
      while (irq_o[hh] !== 1'b1 && n < 30000)
      begin
         @(negedge sys_clk_i);
         n++;
      end
   endtask : wait_irq

   // status bit of an event on port index p, a=6 for wake, 4 for connect
   function automatic logic [15:0] port_bit(input int pp, input int a);
      return 16'h1 << (a + pp % 2);
   endfunction : port_bit

   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict

   // ************************************************************************
   // main sequence
   // ************************************************************************
   initial
   begin
      repeat (10) @(negedge sys_clk_i);
      srst_i = 1'b0;
      // values after reset, unmapped address reads zero
      for (h = 0; h < 2; h++)
      begin
         rd_chk(IEN_ADDR[h], 16'h0000);
         rd_chk(STAT_ADDR[h], 16'h0000);
         rd_chk(RELOAD_ADDR[h], 16'h2ee0);
      end
      rd_chk(16'hc0f0, 16'h0000);
      $display("test reset values done");
      // enable registers keep only their implemented bits
      for (h = 0; h < 2; h++)
         repeat (4)
         begin
            d = 16'($random(seed));
            reg_wr(IEN_ADDR[h], d);
            rd_chk(IEN_ADDR[h], d & EVT_MASK[h]);
         end
      $display("test enables done");
      // transfer done flag, enable gating and write-one clear
      for (h = 0; h < 2; h++)
      begin
         reg_wr(IEN_ADDR[h], 16'h0000);
         @(negedge sys_clk_i) done_req[h] = 1'b1;
         @(negedge sys_clk_i) done_req[h] = 1'b0;
         rd_chk(STAT_ADDR[h], 16'h0001);
         chk(16'(irq_o[h]), 16'h0, "masked irq");
         reg_wr(IEN_ADDR[h], 16'h0001);
         chk(16'(irq_o[h]), 16'h1, "done irq");
         reg_wr(STAT_ADDR[h], 16'hfffe);
         rd_chk(STAT_ADDR[h], 16'h0001);
         reg_wr(STAT_ADDR[h], 16'h0001);
         rd_chk(STAT_ADDR[h], 16'h0000);
         chk(16'(irq_o[h]), 16'h0, "irq drop");
         // a done pulse meets a clear of the same flag, the set wins
         done_req[h] = 1'b1;
         fork
            reg_wr(STAT_ADDR[h], 16'h0001);
            @(negedge sys_clk_i) done_req[h] = 1'b0;
         join
         rd_chk(STAT_ADDR[h], 16'h0001);
         reg_wr(STAT_ADDR[h], 16'h0001);
      end
      $display("test transfer done finished");
      // remote wakeup and connect change on every port
      for (p = 0; p < 4; p++)
      begin
         h = p / 2;
         reg_wr(IEN_ADDR[h], 16'h00f0 ^ port_bit(p, 6));
         @(negedge sys_clk_i) wake_req[p] = 1'b1;
         @(negedge sys_clk_i) wake_req[p] = 1'b0;
         rd_chk(STAT_ADDR[h], port_bit(p, 6));
         chk(16'(irq_o[h]), 16'h0, "masked wake");
         reg_wr(IEN_ADDR[h], 16'h00f0);
         chk(16'(irq_o[h]), 16'h1, "wake irq");
         reg_wr(STAT_ADDR[h], 16'hffff);
         attach[p] = 1'b0;
         repeat (6) @(negedge sys_clk_i);
         rd_chk(STAT_ADDR[h], port_bit(p, 4) | port_bit(p, 2));
         chk(16'(irq_o[h]), 16'h1, "connect irq");
         reg_wr(STAT_ADDR[h], 16'hffff);
         rd_chk(STAT_ADDR[h], port_bit(p, 2));
         attach[p] = 1'b1;
         repeat (6) @(negedge sys_clk_i);
         rd_chk(STAT_ADDR[h], port_bit(p, 4));
         reg_wr(STAT_ADDR[h], 16'hffff);
      end
      $display("test wake and connect done");
      // otg edges, first host only
      reg_wr(IEN_ADDR[0], 16'hc000);
      reg_wr(IEN_ADDR[1], 16'hc000);
      vbus = 1'b1;
      repeat (6) @(negedge sys_clk_i);
      rd_chk(STAT_ADDR[0], 16'h8000);
      chk(16'(irq_o), 16'h1, "otg irq");
      reg_wr(STAT_ADDR[0], 16'hffff);
      id = 1'b1;
      repeat (6) @(negedge sys_clk_i);
      rd_chk(STAT_ADDR[0], 16'h4000);
      reg_wr(STAT_ADDR[0], 16'hffff);
      vbus = 1'b0;
      id   = 1'b0;
      repeat (6) @(negedge sys_clk_i);
      rd_chk(STAT_ADDR[0], 16'hc000);
      rd_chk(STAT_ADDR[1], 16'h0000);
      reg_wr(STAT_ADDR[0], 16'hffff);
      $display("test otg done");
      // counter runs down at 12 of every 20 clocks
      reg_rd(COUNT_ADDR[0], t1);
      repeat (97) @(negedge sys_clk_i);
      reg_rd(COUNT_ADDR[0], d);
      chk(16'((t1 - d) inside {[59:61]}), 16'h1, "tick rate");
      // reload write, read back and frame number clear
      for (h = 0; h < 2; h++)
      begin
         reg_wr(RELOAD_ADDR[h], 16'hc014);
         rd_chk(RELOAD_ADDR[h], 16'h0014);
         chk(16'(clr_cnt[h]), 16'h1, "frame number clear");
      end
      // expiry flag and period set by the new reload value
      for (h = 0; h < 2; h++)
      begin
         reg_wr(IEN_ADDR[h], 16'h0200);
         reg_wr(STAT_ADDR[h], 16'h0200);
         wait_irq(h);
         chk(16'(irq_o[h]), 16'h1, "frame irq");
         t0 = cyc;
         reg_wr(STAT_ADDR[h], 16'h0200);
         reg_rd(COUNT_ADDR[h], d);
         chk(16'(d <= 16'd20), 16'h1, "reloaded count");
         wait_irq(h);
         chk(16'((cyc - t0) inside {[32:38]}), 16'h1, "period");
         reg_wr(IEN_ADDR[h], 16'h0000);
      end
      $display("test frame timer done");
      print_verdict();
   end
endmodule : test_ufe_host_events
